// ===== common/kfei_pkg.sv
package kfei_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int KFEI_AW       = 16;
    localparam int KFEI_DW       = 8;
    localparam int KFEI_MAX_KEYS = 8;
    localparam int KFEI_SMALL_KEYS = 4;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] KFEI_KEY_EN_ADDR  = 16'hFF6E;
    localparam logic [15:0] KFEI_STATUS_ADDR  = 16'hFF70;
    localparam logic [15:0] KFEI_CLEAR_ADDR   = 16'hFF71;
    localparam logic [15:0] KFEI_IRQ_EN_ADDR  = 16'hFF72;
    localparam logic [15:0] KFEI_PIN_LVL_ADDR = 16'hFF73;

    // ------------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] KFEI_KEY_EN_RST  = 8'h00;
    localparam logic [7:0] KFEI_IRQ_EN_RST  = 8'h00;
    localparam logic [7:0] KFEI_STATUS_RST  = 8'h00;
    localparam logic [7:0] KFEI_RDATA_IDLE  = 8'h00;
    localparam logic [7:0] KFEI_PIN_IDLE    = 8'hFF;
    localparam logic [7:0] KFEI_STATUS_MASK = 8'h03;
    localparam int         KFEI_ST_KEY      = 0;
    localparam int         KFEI_ST_OVR      = 1;
    localparam logic [7:0] KFEI_MASK_SMALL  = 8'h0F;
    localparam logic [7:0] KFEI_MASK_LARGE  = 8'hFF;

    // ------------------------------------------------------------------
    // Channel mask of a variant
    // ------------------------------------------------------------------
    function automatic logic [7:0] kfei_chan_mask(input int num_keys);
        kfei_chan_mask = (num_keys > KFEI_SMALL_KEYS) ? KFEI_MASK_LARGE : KFEI_MASK_SMALL;
    endfunction : kfei_chan_mask

endpackage : kfei_pkg

// ===== common/kfei_key_if.sv
`timescale 1ns/10ps
`default_nettype none

interface kfei_key_if;
    logic [7:0] pins;
    logic [7:0] enable;
    logic       edge_pulse;

    modport detector (
        input  pins,
        input  enable,
        output edge_pulse
    );

    modport ctrl (
        output pins,
        output enable,
        input  edge_pulse
    );
endinterface : kfei_key_if

`default_nettype wire

// ===== hdl/kfei_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none

module kfei_edge_detect
    import kfei_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Key lines and enables
    kfei_key_if.detector     key_if
);

    // ------------------------------------------------------------------
    // Sampling and falling-edge detection
    // ------------------------------------------------------------------
    logic [7:0] sample_q;
    logic [7:0] sample_d;
    logic [7:0] prev_q;
    logic [7:0] prev_d;
    logic       edge_q;
    logic       edge_d;
    logic [7:0] fall;

    always_comb begin
        sample_d = key_if.pins;
        prev_d   = sample_q;
        fall     = prev_q & ~sample_q & key_if.enable;
        edge_d   = |fall;
    end

    // Idle level is high so a pin held low at reset release reads as a falling edge
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sample_q <= KFEI_PIN_IDLE;
            prev_q   <= KFEI_PIN_IDLE;
            edge_q   <= 1'b0;
        end else begin
            sample_q <= sample_d;
            prev_q   <= prev_d;
            edge_q   <= edge_d;
        end
    end

    assign key_if.edge_pulse = edge_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [1:0] live_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            live_q <= 2'h0;
        end else if (live_q != 2'h3) begin
            live_q <= live_q + 2'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_pin_fall_flags: assert property ((live_q == 2'h3)
        && |($past(key_if.pins, 3) & ~$past(key_if.pins, 2) & $past(key_if.enable, 1))
        |-> key_if.edge_pulse)
        else $error("enabled falling edge gave no pulse");

    a_pulse_has_cause: assert property (key_if.edge_pulse && (live_q == 2'h3)
        |-> |($past(key_if.pins, 3) & ~$past(key_if.pins, 2) & $past(key_if.enable, 1)))
        else $error("pulse without enabled falling edge");

    a_level_no_pulse: assert property ((key_if.pins == $past(key_if.pins))[*3]
        |=> !key_if.edge_pulse)
        else $error("pulse on steady key lines");

endmodule : kfei_edge_detect

`default_nettype wire

// ===== hdl/kfei_key_irq.sv
// Functional notes
// - A falling edge on an enabled key line raises the key interrupt request.
// - Each key line has an enable bit: 0 ignores it, 1 detects its falling edges.
// - Reset clears the key enable register to all zeros.
// - The key enable register is an 8-bit read/write register at FF6E.
// - The small variant has four key channels and the large one eight.
// - Lines with a clear enable bit stay ordinary port pins.
// - The request reaches the CPU only while its flag is set and not masked.
`timescale 1ns/10ps
`default_nettype none

module kfei_key_irq
    import kfei_pkg::*;
#(
    parameter int NUM_KEYS = KFEI_MAX_KEYS
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Register port
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // Key lines
    input  wire logic [7:0]  key_input_pin,
    output logic      [7:0]  key_detect_en,
    // Interrupt
    output logic             key_irq
);

    // ------------------------------------------------------------------
    // Variant
    // ------------------------------------------------------------------
    localparam logic [7:0] CHAN_MASK = kfei_chan_mask(NUM_KEYS);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] reg_addr);
        reg_hit = (a == reg_addr);
    endfunction : reg_hit

    // Reads outside these addresses return zero
    function automatic logic reg_mapped(input logic [15:0] a);
        reg_mapped = reg_hit(a, KFEI_KEY_EN_ADDR) || reg_hit(a, KFEI_STATUS_ADDR)
            || reg_hit(a, KFEI_IRQ_EN_ADDR) || reg_hit(a, KFEI_PIN_LVL_ADDR);
    endfunction : reg_mapped

    // ------------------------------------------------------------------
    // Edge detector
    // ------------------------------------------------------------------
    kfei_key_if key_if ();

    logic [7:0] key_input_enable_q;
    logic [7:0] key_input_enable_d;

    assign key_if.pins   = key_input_pin;
    assign key_if.enable = key_input_enable_q;

    kfei_edge_detect u_edge (
        .clock  (clock),
        .rstn   (rstn),
        .key_if (key_if)
    );

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    logic wr_key_en;
    logic wr_clear;
    logic wr_irq_en;

    always_comb begin
        wr_key_en = wr && reg_hit(addr, KFEI_KEY_EN_ADDR);
        wr_clear  = wr && reg_hit(addr, KFEI_CLEAR_ADDR);
        wr_irq_en = wr && reg_hit(addr, KFEI_IRQ_EN_ADDR);
    end

    // ------------------------------------------------------------------
    // Key enable register
    // ------------------------------------------------------------------
    always_comb begin
        key_input_enable_d = key_input_enable_q;
        if (wr_key_en) begin
            // Bits above the variant's channels stay zero
            key_input_enable_d = wdata & CHAN_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            key_input_enable_q <= KFEI_KEY_EN_RST;
        end else begin
            key_input_enable_q <= key_input_enable_d;
        end
    end

    // ------------------------------------------------------------------
    // Status, clear and interrupt enable
    // ------------------------------------------------------------------
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] irq_en_q;
    logic [7:0] irq_en_d;
    logic [7:0] status_set;
    logic [7:0] status_clr;
    logic       key_irq_q;
    logic       key_irq_d;

    always_comb begin
        status_set = KFEI_STATUS_RST;
        status_set[KFEI_ST_KEY] = key_if.edge_pulse;
        status_set[KFEI_ST_OVR] = key_if.edge_pulse && status_q[KFEI_ST_KEY];
        status_clr = wr_clear ? wdata : KFEI_STATUS_RST;
        // A new event in the clearing cycle is kept
        status_d   = ((status_q & ~status_clr) | status_set) & KFEI_STATUS_MASK;
        irq_en_d   = wr_irq_en ? (wdata & KFEI_STATUS_MASK) : irq_en_q;
        key_irq_d  = |(status_d & irq_en_d);
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            status_q  <= KFEI_STATUS_RST;
            irq_en_q  <= KFEI_IRQ_EN_RST;
            key_irq_q <= 1'b0;
        end else begin
            status_q  <= status_d;
            irq_en_q  <= irq_en_d;
            key_irq_q <= key_irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = KFEI_RDATA_IDLE;
        if (rd) begin
            case (addr)
                KFEI_KEY_EN_ADDR: begin
                    rdata_d = key_input_enable_q;
                end
                KFEI_STATUS_ADDR: begin
                    rdata_d = status_q;
                end
                KFEI_IRQ_EN_ADDR: begin
                    rdata_d = irq_en_q;
                end
                KFEI_PIN_LVL_ADDR: begin
                    // Raw levels, whatever the enables, for port use
                    rdata_d = key_input_pin;
                end
                default: begin
                    rdata_d = KFEI_RDATA_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rdata_q <= KFEI_RDATA_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata         = rdata_q;
    assign key_irq       = key_irq_q;
    assign key_detect_en = key_input_enable_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_en_write;
        wr && (addr == KFEI_KEY_EN_ADDR);
    endsequence

    sequence s_all_off;
        (key_input_enable_q == KFEI_KEY_EN_RST)[*3];
    endsequence

    sequence s_clear_key;
        wr && (addr == KFEI_CLEAR_ADDR) && wdata[KFEI_ST_KEY];
    endsequence

    // Flag still set after the clear, then the level follows the enabled flags
    sequence s_flag_then_irq;
        status_q[KFEI_ST_KEY] ##1 key_irq == |(status_q & irq_en_q);
    endsequence

    a_reset_clears_en: assert property (@(posedge clock) disable iff (1'b0)
        $rose(rstn) |-> (key_input_enable_q == KFEI_KEY_EN_RST) && !key_irq)
        else $error("enable register or irq not cleared by reset");

    a_en_write_data: assert property (s_en_write
        |=> key_input_enable_q == ($past(wdata) & CHAN_MASK))
        else $error("enable register did not take written byte");

    a_en_read_back: assert property (rd && (addr == KFEI_KEY_EN_ADDR) && !wr
        |=> rdata == $past(key_input_enable_q) ##1 (rdata == KFEI_RDATA_IDLE || $past(rd)))
        else $error("enable register read back wrong");

    a_upper_bits_zero: assert property ((key_input_enable_q & ~CHAN_MASK) == KFEI_RDATA_IDLE)
        else $error("enable bit set beyond the variant's channels");

    a_all_off_quiet: assert property (s_all_off |=> !key_if.edge_pulse)
        else $error("edge pulse while every key line is disabled");

    a_edge_sets_flag: assert property (key_if.edge_pulse |=> status_q[KFEI_ST_KEY])
        else $error("key edge did not set the request flag");

    a_set_beats_clr: assert property (s_clear_key and key_if.edge_pulse |=> s_flag_then_irq)
        else $error("event lost in the clearing cycle");

    a_clear_drops_flag: assert property (s_clear_key and !key_if.edge_pulse
        |=> !status_q[KFEI_ST_KEY])
        else $error("clear did not drop the request flag");

    a_masked_no_irq: assert property (irq_en_q == KFEI_IRQ_EN_RST && !wr |=> !key_irq)
        else $error("irq raised while every source is masked");

    a_flag_and_unmask: assert property (status_q[KFEI_ST_KEY] && irq_en_q[KFEI_ST_KEY]
        |-> key_irq)
        else $error("unmasked request flag gave no irq");

    // ------------------------------------------------------------------
    // Flag and mask checks
    // ------------------------------------------------------------------
    a_irq_en_write: assert property (wr_irq_en
        |=> irq_en_q == ($past(wdata) & KFEI_STATUS_MASK))
        else $error("interrupt enable did not take written bits");

    a_irq_tracks_flags: assert property (key_irq == |(status_q & irq_en_q))
        else $error("irq level differs from enabled flags");

    // Overrun marks a second edge before software clears the first
    a_overrun_sets: assert property (key_if.edge_pulse && status_q[KFEI_ST_KEY]
        |=> status_q[KFEI_ST_OVR])
        else $error("edge on a set flag did not mark overrun");

    a_flag_needs_edge: assert property (!key_if.edge_pulse && !status_q[KFEI_ST_KEY]
        |=> !status_q[KFEI_ST_KEY])
        else $error("request flag set without a key edge");

    a_ovr_needs_edge: assert property (!key_if.edge_pulse && !status_q[KFEI_ST_OVR]
        |=> !status_q[KFEI_ST_OVR])
        else $error("overrun flag set without a key edge");

    a_flag_sticky: assert property (status_q[KFEI_ST_KEY] && !wr_clear
        |=> status_q[KFEI_ST_KEY])
        else $error("request flag dropped without a clear");

    // Only software may move the enables
    a_enable_holds: assert property (!wr_key_en |=> $stable(key_input_enable_q))
        else $error("enable register changed without a write");

    // Writes to unmapped or read-only addresses change nothing
    a_other_write_quiet: assert property (wr && !wr_key_en && !wr_irq_en
        |=> $stable(irq_en_q) && $stable(key_input_enable_q))
        else $error("write to another address changed an enable");

    a_port_en_copy: assert property (s_en_write
        |=> key_detect_en == ($past(wdata) & CHAN_MASK))
        else $error("port enables do not follow the enable register");

    // ------------------------------------------------------------------
    // Read port checks
    // ------------------------------------------------------------------
    // Software sees the raw lines whatever the enables
    a_pin_read_raw: assert property (rd && reg_hit(addr, KFEI_PIN_LVL_ADDR)
        |=> rdata == $past(key_input_pin))
        else $error("pin level read differs from the key lines");

    a_status_read: assert property (rd && reg_hit(addr, KFEI_STATUS_ADDR)
        |=> rdata == $past(status_q))
        else $error("status read differs from the flags");

    a_irq_en_read: assert property (rd && reg_hit(addr, KFEI_IRQ_EN_ADDR)
        |=> rdata == $past(irq_en_q))
        else $error("interrupt enable read back wrong");

    a_idle_read_zero: assert property (!(rd && reg_mapped(addr))
        |=> rdata == KFEI_RDATA_IDLE)
        else $error("read data not zero outside a mapped read");

endmodule : kfei_key_irq

`default_nettype wire

// ===== test/kfei_keys_model.sv
`timescale 1ns/10ps
`default_nettype none

module kfei_keys_model (
    // Clock
    input  wire logic       clock,
    // Key lines
    output logic      [7:0] key_input_pin
);
    // Pull-ups hold every released key high; the lines carry no second I2C traffic
    initial key_input_pin <= 8'hFF;

    // A pressed key pulls its line low, changed just after an edge
    task automatic hold(input logic [7:0] pressed);
        @(posedge clock);
        key_input_pin <= ~pressed;
    endtask : hold
endmodule : kfei_keys_model

`default_nettype wire

// ===== test/key_falling_edge_interrupt_tb.sv
`timescale 1ns/10ps
`default_nettype none

module key_falling_edge_interrupt_tb;
    import kfei_pkg::*;
    logic        clock, rstn, wr, rd, wr_s, irq, irq_s;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, rdata_s, en, en_s, pins;
    int          mismatches = 0;
    int          comparisons = 0;

    // Small variant only ever sees zero in its upper enable bits
    assign wr_s = wr && ((addr != KFEI_KEY_EN_ADDR) || (wdata[7:4] == 4'h0));

    kfei_keys_model keys (.clock(clock), .key_input_pin(pins));
    kfei_key_irq #(.NUM_KEYS(8)) uut (.clock(clock), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .key_input_pin(pins),
        .key_detect_en(en), .key_irq(irq));
    kfei_key_irq #(.NUM_KEYS(4)) uut_s (.clock(clock), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr_s), .rd(rd), .rdata(rdata_s), .key_input_pin(pins),
        .key_detect_en(en_s), .key_irq(irq_s));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s read %h not %h", $time, what, got, exp);
        end
    endtask : check_byte

    task automatic check_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s is %b not %b", $time, what, got, exp);
        end
    endtask : check_bit

    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask : bus_wr

    task automatic bus_chk(input logic [15:0] a, input logic [7:0] exp, input logic [7:0] exp_s);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1;
        check_byte(rdata, exp, "large read");
        check_byte(rdata_s, exp_s, "small read");
    endtask : bus_chk

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    task automatic wait_irq();
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            #1;
            if (irq === 1'b1) return;
        end
        mismatches++;
        $display("unexpected at %0t: interrupt never rose", $time);
        give_verdict();
    endtask : wait_irq

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        rstn  <= 1'b0;
        wr    <= 1'b0;
        rd    <= 1'b0;
        addr  <= 16'h0000;
        wdata <= 8'h00;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        settle(1);
        check_byte(en, 8'h00, "enables after reset");
        check_bit(irq, 1'b0, "irq after reset");
        bus_chk(KFEI_KEY_EN_ADDR, 8'h00, 8'h00);
        $display("test reset done");

        bus_wr(KFEI_KEY_EN_ADDR, 8'hA5);
        bus_chk(KFEI_KEY_EN_ADDR, 8'hA5, 8'h00);
        check_byte(en, 8'hA5, "port enables");
        bus_wr(16'hFF60, 8'h3C);
        bus_chk(16'hFF60, 8'h00, 8'h00);
        bus_wr(KFEI_KEY_EN_ADDR, 8'hA5 | 8'h02);
        bus_chk(KFEI_KEY_EN_ADDR, 8'hA7, 8'h00);
        $display("test registers done");

        bus_wr(KFEI_IRQ_EN_ADDR, 8'h01);
        keys.hold(8'h58);
        settle(6);
        check_bit(irq, 1'b0, "disabled lines");
        bus_chk(KFEI_STATUS_ADDR, 8'h00, 8'h00);
        bus_chk(KFEI_PIN_LVL_ADDR, 8'hA7, 8'hA7);
        bus_chk(KFEI_IRQ_EN_ADDR, 8'h01, 8'h01);
        bus_chk(KFEI_CLEAR_ADDR, 8'h00, 8'h00);
        keys.hold(8'h00);
        $display("test disabled lines done");

        for (int n = 0; n < 8; n++) begin
            bus_wr(KFEI_IRQ_EN_ADDR, 8'h00);
            bus_wr(KFEI_KEY_EN_ADDR, 8'h01 << n);
            bus_wr(KFEI_CLEAR_ADDR, 8'h03);
            bus_wr(KFEI_IRQ_EN_ADDR, 8'h01);
            keys.hold(8'h01 << n);
            wait_irq();
            check_bit(irq_s, n < 4, "small irq");
            keys.hold(8'h00);
            bus_chk(KFEI_STATUS_ADDR, 8'h01, (n < 4) ? 8'h01 : 8'h00);
            bus_wr(KFEI_CLEAR_ADDR, 8'h03);
            settle(2);
            check_bit(irq, 1'b0, "irq after clear");
        end
        $display("test channels done");

        bus_wr(KFEI_IRQ_EN_ADDR, 8'h00);
        bus_wr(KFEI_KEY_EN_ADDR, 8'hFF);
        bus_wr(KFEI_CLEAR_ADDR, 8'h03);
        keys.hold(8'h21);
        settle(6);
        check_bit(irq, 1'b0, "masked irq");
        keys.hold(8'h00);
        settle(3);
        bus_chk(KFEI_STATUS_ADDR, 8'h01, 8'h00);
        keys.hold(8'h01);
        settle(6);
        bus_chk(KFEI_STATUS_ADDR, 8'h03, 8'h00);
        bus_wr(KFEI_IRQ_EN_ADDR, 8'h01);
        settle(2);
        check_bit(irq, 1'b1, "unmasked irq");
        keys.hold(8'h00);
        bus_wr(KFEI_CLEAR_ADDR, 8'h03);
        settle(1);
        check_bit(irq, 1'b0, "irq after mask clear");
        keys.hold(8'h02);
        settle(1);
        bus_wr(KFEI_CLEAR_ADDR, 8'h03);
        bus_chk(KFEI_STATUS_ADDR, 8'h01, 8'h00);
        check_bit(irq, 1'b1, "event in clearing cycle");
        $display("test mask done");

        @(posedge clock);
        rstn <= 1'b0;
        @(posedge clock);
        rstn <= 1'b1;
        settle(1);
        check_byte(en, 8'h00, "enables after second reset");
        check_bit(irq, 1'b0, "irq after second reset");
        $display("test second reset done");
        give_verdict();
    end
endmodule : key_falling_edge_interrupt_tb

`default_nettype wire
